// [pkg/crc_pkg.sv]
// Constants, carriers and helper functions of the CRC accelerator core.
// Assumes one AHB-Lite slave select and a 32-bit word-only software interface.
//
// Behaviour
// - Whole 32-bit words are written over the bus.
// - Three control bits select input mirroring.
// - Each input write updates the result register while the enable bit is set.
// - Result reads show all words written so far.
// - Next checksum folds current result with new word.
// - Software may write a seed into result.
// - Polynomial register is programmable up to 32 bits.
// - Both MSB-first and LSB-first orders supported.
// - Checksum occupies polynomial-width bits, MSBs if left-justified.
// - LSB-first 16-bit example uses low halfword.
// - MSB-first 16-bit example uses high halfword.
package crc_pkg;

  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned ADDR_W     = 12;

  // Register byte offsets inside the 4 KB slave window.
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] INPUT_OFF  = 12'h004;
  localparam logic [11:0] RESULT_OFF = 12'h008;
  localparam logic [11:0] CRC_POLYNOMIAL_OFF   = 12'h00C;

  // Control field positions and reset values.
  localparam int unsigned CTRL_EN_POS  = 0;
  localparam int unsigned CTRL_LSB_POS = 1;
  localparam int unsigned CTRL_MIR_POS = 2;
  localparam int unsigned CTRL_W       = 5;
  localparam logic [4:0]  CTRL_RST     = 5'h00;
  localparam logic [31:0] RESULT_RST   = 32'h0000_0000;
  localparam logic [31:0] CRC_POLYNOMIAL_RST     = 32'h0000_0000;

  // Control register contents, bit 0 first from the right.
  typedef struct packed {
    logic [2:0] mirror;
    logic       lsb_first;
    logic       enable;
  } ctrl_s;

  // Captured AHB address phase.
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } dphase_s;

  // Applies bit-in-byte, byte-in-word and halfword-in-word mirroring in turn.
  function automatic logic [31:0] mirror_word(input logic [31:0] d, input logic [2:0] m);
    logic [31:0] w;
    w = d;
    if (m[0]) begin
      for (int i = 0; i < 32; i++) begin
        w[i] = d[(i & ~7) + 7 - (i & 7)];
      end
    end
    if (m[1]) begin
      w = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
    if (m[2]) begin
      w = {w[15:0], w[31:16]};
    end
    return w;
  endfunction

  // Folds one word into the checksum, one bit per loop pass.
  function automatic logic [31:0] crc_word(input logic [31:0] r, input logic [31:0] p,
                                           input logic [31:0] d, input logic lsb);
    logic [31:0] c;
    logic        fb;
    c  = r;
    fb = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (lsb) begin
        fb = c[0] ^ d[i];
        c  = {1'b0, c[31:1]};
      end else begin
        fb = c[31] ^ d[31-i];
        c  = {c[30:0], 1'b0};
      end
      if (fb) begin
        c = c ^ p;
      end
    end
    return c;
  endfunction

endpackage

// [rtl/crc_accelerator_core.sv]
// CRC accelerator core: a word FIFO and the AHB-Lite register slave around the engine.
// Assumes a single AHB-Lite master, word-only transfers and hready fed back from hreadyout.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Word FIFO with valid and ready on both sides.
module crc_word_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = PW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at the depth.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // Occupancy moves only when exactly one side transfers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top level: register slave, input queue and checksum engine.
module crc_accelerator_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata
);
  crc_pkg::dphase_s dp_reg;
  crc_pkg::ctrl_s   ctrl_reg;
  logic [31:0]      result_reg;
  logic [31:0]      crc_polynomial_reg;
  logic [31:0]      result_next;
  logic             addr_take;
  logic             dp_input_wr;
  logic             dp_result;
  logic             dp_cfg_wr;
  logic             dp_done;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [31:0]      fifo_out_data;
  logic             eng_ready;
  logic             pop;
  logic             result_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Only word transfers exist, so hsize is not decoded.
  assign addr_take   = hsel && hready && htrans[1];
  assign dp_input_wr = dp_reg.valid && dp_reg.write && (dp_reg.addr == crc_pkg::INPUT_OFF);
  assign dp_result   = dp_reg.valid && (dp_reg.addr == crc_pkg::RESULT_OFF);
  assign dp_cfg_wr   = dp_reg.valid && dp_reg.write &&
                       ((dp_reg.addr == crc_pkg::CTRL_OFF) || (dp_reg.addr == crc_pkg::CRC_POLYNOMIAL_OFF));
  assign dp_done     = dp_reg.valid && hreadyout;
  assign result_wr   = dp_done && dp_reg.write && (dp_reg.addr == crc_pkg::RESULT_OFF);
  assign hresp       = 1'b0;

  // An input write waits for queue room; any result access waits for the queue to drain.
  always_comb begin
    if (dp_input_wr) begin
      hreadyout = fifo_in_ready;
    end else if (dp_result) begin
      hreadyout = !fifo_out_valid;
    end else begin
      hreadyout = 1'b1;
    end
  end

  // The address phase is captured whenever the bus is ready.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_reg <= '0;
    end else if (hready) begin
      dp_reg <= '{valid: addr_take, write: hwrite, addr: haddr[crc_pkg::ADDR_W-1:0]};
    end
  end

  // Read mux; the input register and unmapped offsets read as zero.
  always_comb begin
    case (dp_reg.addr)
      crc_pkg::CTRL_OFF:   hrdata = {27'h0000000, ctrl_reg};
      crc_pkg::RESULT_OFF: hrdata = result_reg;
      crc_pkg::CRC_POLYNOMIAL_OFF:   hrdata = crc_polynomial_reg;
      default:             hrdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software-written settings.

  // Control holds enable, order and the three mirror enables.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= crc_pkg::CTRL_RST;
    end else if (dp_done && dp_reg.write && (dp_reg.addr == crc_pkg::CTRL_OFF)) begin
      ctrl_reg <= hwdata[crc_pkg::CTRL_W-1:0];
    end
  end

  // The polynomial is stored whole; its justification is software's business.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_polynomial_reg <= crc_pkg::CRC_POLYNOMIAL_RST;
    end else if (dp_done && dp_reg.write && (dp_reg.addr == crc_pkg::CRC_POLYNOMIAL_OFF)) begin
      crc_polynomial_reg <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input queue and engine.

  // Words queue here so back-to-back writes never lose data.
  crc_word_fifo #(
    .WIDTH (crc_pkg::DATA_W),
    .DEPTH (crc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (dp_input_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata),
    .out_valid (fifo_out_valid),
    .out_ready (eng_ready),
    .out_data  (fifo_out_data)
  );

  // The engine pauses while control or polynomial are being rewritten.
  assign eng_ready   = !dp_cfg_wr;
  assign pop         = fifo_out_valid && eng_ready;
  assign result_next = crc_pkg::crc_word(result_reg, crc_polynomial_reg,
                                         crc_pkg::mirror_word(fifo_out_data, ctrl_reg.mirror),
                                         ctrl_reg.lsb_first);

  // A seed write wins; otherwise each queued word folds in when enabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= crc_pkg::RESULT_RST;
    end else if (result_wr) begin
      result_reg <= hwdata;
    end else if (pop && ctrl_reg.enable) begin
      result_reg <= result_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_input_taken;
    dp_input_wr && hreadyout;
  endsequence

  sequence s_fold;
    pop && ctrl_reg.enable && !result_wr;
  endsequence

  sequence s_result_wait;
    dp_result && fifo_out_valid;
  endsequence

  property p_input_queued;
    s_input_taken |=> fifo_out_valid;
  endproperty
  a_input_queued: assert property (p_input_queued)
    else $error("Accepted input word did not reach the queue.");

  property p_input_backpressure;
    dp_input_wr && !fifo_in_ready |-> !hreadyout;
  endproperty
  a_input_backpressure: assert property (p_input_backpressure)
    else $error("Input write completed while the queue was full.");

  property p_fold;
    s_fold |=> result_reg == crc_pkg::crc_word($past(result_reg), $past(crc_polynomial_reg),
      crc_pkg::mirror_word($past(fifo_out_data), $past(ctrl_reg.mirror)),
      $past(ctrl_reg.lsb_first));
  endproperty
  a_fold: assert property (p_fold)
    else $error("Result did not take the folded checksum.");

  property p_disabled_hold;
    pop && !ctrl_reg.enable && !result_wr |=> $stable(result_reg);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("Result changed while the engine was disabled.");

  property p_result_wait;
    s_result_wait |-> !hreadyout ##1 (dp_result throughout (!hreadyout [*1]) or !fifo_out_valid);
  endproperty
  a_result_wait: assert property (p_result_wait)
    else $error("Result access completed with words still queued.");

  property p_drain_bound;
    (s_result_wait and !dp_cfg_wr) |-> ##[1:4] hreadyout;
  endproperty
  a_drain_bound: assert property (p_drain_bound)
    else $error("Queue did not drain within its depth.");

  property p_result_read;
    dp_done && !dp_reg.write && (dp_reg.addr == crc_pkg::RESULT_OFF) |-> hrdata == result_reg;
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("Result read did not show the result register.");

  property p_seed;
    result_wr |=> result_reg == $past(hwdata);
  endproperty
  a_seed: assert property (p_seed)
    else $error("Seed write was not stored.");

  property p_crc_polynomial;
    dp_done && dp_reg.write && (dp_reg.addr == crc_pkg::CRC_POLYNOMIAL_OFF) |=> crc_polynomial_reg == $past(hwdata);
  endproperty
  a_crc_polynomial: assert property (p_crc_polynomial)
    else $error("Polynomial write was not stored.");

  property p_ctrl;
    dp_done && dp_reg.write && (dp_reg.addr == crc_pkg::CTRL_OFF)
      |=> ctrl_reg == $past(hwdata[4:0]) ##1 $stable(ctrl_reg) || $past(dp_done);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("Control write was not stored.");

  property p_fold_next;
    s_input_taken ##1 !dp_cfg_wr |-> pop;
  endproperty
  a_fold_next: assert property (p_fold_next)
    else $error("Accepted input word was not taken by the engine.");

  property p_result_no_wait;
    dp_result && !fifo_out_valid |-> hreadyout;
  endproperty
  a_result_no_wait: assert property (p_result_no_wait)
    else $error("Result access waited with the queue empty.");

  property p_crc_polynomial_hold;
    !(dp_done && dp_reg.write && (dp_reg.addr == crc_pkg::CRC_POLYNOMIAL_OFF)) |=> $stable(crc_polynomial_reg);
  endproperty
  a_crc_polynomial_hold: assert property (p_crc_polynomial_hold)
    else $error("Polynomial changed without a write.");

  property p_ctrl_hold;
    !(dp_done && dp_reg.write && (dp_reg.addr == crc_pkg::CTRL_OFF)) |=> $stable(ctrl_reg);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("Control changed without a write.");
endmodule

// [tb/crc_bus_master.sv]
// Bus master model that stands in for the processor or a software-driven DMA.
// It assumes that hready is the slave's hreadyout and that it issues one transfer at a time.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module crc_bus_master (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  logic stuck;

  // The bus starts idle and no wait has run out yet.
  initial begin
    stuck = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // This task runs one single transfer, always of a whole 32-bit word.
  // The caller computes any source address, because the block holds no address logic.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 200);
    if (n >= 200) stuck = 1'b1;
    // The address lines are released with a changed value so that stale data cannot pass.
    hsel <= 1'b0;
    haddr <= ~a;
    htrans <= 2'b00;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 200);
    if (n >= 200) stuck = 1'b1;
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule

// [tb/crc_accelerator_core_test.sv]
// Self-checking bench of the CRC accelerator: it reaches the registers over AHB-Lite.
// It assumes the register map and control layout that the package declares.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module crc_accelerator_core_test;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          mismatches;
  int          n_tests;

  // The clock has a period of 25 ns.
  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;

  // The design sits here, with hready fed back from hreadyout.
  crc_accelerator_core i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );

  // The master model drives the bus in place of the processor.
  crc_bus_master i_master (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // This reference applies the mirroring levels that are enabled, in their fixed order.
  function automatic logic [31:0] mirror_ref(input logic [31:0] d, input logic [2:0] m);
    logic [31:0] w;
    w = d;
    for (int i = 0; i < 32; i++) begin
      if (m[0]) w[i] = d[8 * (i / 8) + 7 - i % 8];
    end
    if (m[1]) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
    if (m[2]) w = {w[15:0], w[31:16]};
    return w;
  endfunction

  // This reference folds one word into the checksum, MSB first or LSB first.
  function automatic logic [31:0] crc_ref(input logic [31:0] r, input logic [31:0] p,
                                          input logic [31:0] d, input logic lsb);
    logic b;
    for (int i = 0; i < 32; i++) begin
      b = lsb ? (r[0] ^ d[i]) : (r[31] ^ d[31 - i]);
      r = lsb ? (r >> 1) : (r << 1);
      if (b) r = r ^ p;
    end
    return r;
  endfunction

  // This task prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // This task compares a read word with the expected word.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t read %h, expected %h", $time, got, exp);
    end
  endtask

  // This task checks that the slave answered with an OKAY response.
  task automatic check_okay(input logic resp);
    n_tests++;
    if (resp !== 1'b0) begin
      mismatches++;
      $display("ERROR %0t response was not OKAY", $time);
    end
  endtask

  // This task runs one bus transfer and stops the run if a wait runs out.
  task automatic rw(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    i_master.xfer(wr, a, wd, rd);
    check_okay(hresp);
    if (i_master.stuck) begin
      mismatches++;
      $display("ERROR %0t bus wait ran out", $time);
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // This task configures the engine, seeds it and feeds words, reading after each or at the end.
  task automatic run_block(input logic [31:0] ctl, input logic [31:0] crc_polynomial,
                           input logic [31:0] seed, input int n, input logic each);
    logic [31:0] exp;
    logic [31:0] w;
    rw(1'b1, 32'h0000_000C, crc_polynomial);
    rw(1'b1, 32'h0000_0000, ctl);
    rw(1'b1, 32'h0000_0008, seed);
    rw(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd, seed);
    exp = seed;
    for (int i = 0; i < n; i++) begin
      w = 32'h9E37_79B9 ^ (32'h0101_0203 << i);
      rw(1'b1, 32'h0000_0004, w);
      if (ctl[0]) exp = crc_ref(exp, crc_polynomial, mirror_ref(w, ctl[4:2]), ctl[1]);
      if (each || i == n - 1) begin
        rw(1'b0, 32'h0000_0008, 32'h0000_0000);
        check(rd, exp);
      end
    end
  endtask

  // The reset values, the unmapped offset and the control field width are checked here.
  task automatic t_map;
    for (int i = 0; i < 5; i++) begin
      rw(1'b0, 32'(4 * i), 32'h0000_0000);
      check(rd, 32'h0000_0000);
    end
    rw(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    rw(1'b0, 32'h0000_0010, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    rw(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
    rw(1'b0, 32'h0000_0000, 32'h0000_0000);
    check(rd, 32'h0000_001F);
    rw(1'b1, 32'h0000_000C, 32'h8765_4321);
    rw(1'b0, 32'h0000_000C, 32'h0000_0000);
    check(rd, 32'h8765_4321);
  endtask

  // A 16-bit polynomial runs MSB first, left-justified in the upper half.
  task automatic t_msb16;
    run_block(32'h0000_0001, 32'h1021_0000, 32'hFFFF_0000, 4, 1'b1);
  endtask

  // The same polynomial runs LSB first, right-justified in the lower half.
  task automatic t_lsb16;
    run_block(32'h0000_0003, 32'h0000_8408, 32'h0000_FFFF, 4, 1'b1);
  endtask

  // Every mirroring setting is tried in both orders with a full 32-bit polynomial.
  task automatic t_mirror;
    for (int m = 0; m < 16; m++) begin
      run_block(32'({m, 1'b1}), 32'h04C1_1DB7, 32'hFFFF_FFFF, 2, 1'b1);
    end
  endtask

  // Input words are written one after another and read once at the end; the queue has already drained, so the read does not wait.
  task automatic t_burst;
    run_block(32'h0000_0001, 32'h04C1_1DB7, 32'h0000_0000, 6, 1'b0);
  endtask

  // Words written while the engine is off leave the result unchanged.
  task automatic t_disabled;
    run_block(32'h0000_0002, 32'h0000_8408, 32'h0000_1234, 3, 1'b1);
  endtask

  // The main sequence holds reset for 3 cycles, then runs the scenarios.
  initial begin
    mismatches = 0;
    n_tests = 0;
    hresetn = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_map();
    t_msb16();
    t_lsb16();
    t_mirror();
    t_burst();
    t_disabled();
    wrap_up();
  end
endmodule
